/* cfs_pkg.sv */
// constants and types for the converter fault status bank
package cfs_pkg;
	localparam logic [7:0] OFF_SUPPLY = 8'hd4;
	localparam logic [7:0] OFF_OVERCURRENT = 8'hd5;
	localparam logic [7:0] OFF_SERIOUS = 8'hd6;
	localparam logic [7:0] OFF_BUS_LIMIT = 8'hd7;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// implemented bits per register, the rest read zero
	localparam logic [7:0] MASK_SUPPLY = 8'h31;
	localparam logic [7:0] MASK_OVERCURRENT = 8'hb7;
	localparam logic [7:0] MASK_SERIOUS = 8'h14;
	localparam logic [7:0] MASK_BUS_LIMIT = 8'hff;
	localparam int BIT_GATE_DRIVE_BAD = 0;
	localparam int BIT_AUX_OV = 4;
	localparam int BIT_AUX_UV = 5;
	localparam int BIT_OC_ONE = 0;
	localparam int BIT_OC_TWO = 1;
	localparam int BIT_NEG_OC = 2;
	localparam int BIT_CCL = 4;
	localparam int BIT_AVG_LIMIT = 5;
	localparam int BIT_THERMAL = 7;
	localparam int BIT_CONT_OC_TWO = 2;
	localparam int BIT_CONT_NEG_OC = 4;
	// junction temperature limit in degrees Celsius, compared outside
	localparam int THERMAL_LIMIT_C = 150;
	// a condition must stand for more than this many cycles
	localparam logic [2:0] PERSIST_LIMIT = 3'h3;
	localparam logic [2:0] PERSIST_TRIP = 3'h4;

	typedef struct packed {
		logic gate_drive_supply_bad;
		logic aux_micro_regulator_ov;
		logic aux_micro_regulator_uv;
		logic overcurrent_level_one;
		logic overcurrent_level_two;
		logic negative_overcurrent;
		logic constant_current_loop;
		logic average_current_limit_fault;
		logic thermal_over_limit;
		logic [3:0] low_voltage_bus_limit;
		logic [3:0] high_voltage_bus_limit;
	} cfs_fault_s;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wr_data;
	} cfs_access_s;
endpackage

/* cfs_fault_status_bank.sv */
// fault status register bank with persistence shutdown logic
// Contract
// [R1] bit 0 of supply register flags gate drive supply outside 4.8V..5.6V
// [R2] bit 4 of supply register flags aux regulator overvoltage
// [R3] bit 5 of supply register flags aux regulator undervoltage
// [R4] overcurrent bit 0 sets on level one trip; phase recorded elsewhere
// [R5] overcurrent bit 1 sets on level two trip; phase recorded elsewhere
// [R6] overcurrent bit 2 sets on negative overcurrent; same location register
// [R7] overcurrent bit 4 shows constant current loop operation live
// [R8] overcurrent bit 5 sets on average current limit fault
// [R9] overcurrent bit 7 sets when junction exceeds 150 C
// [R10] level two over three cycles: FETs off, serious bit 2 set
// [R11] negative overcurrent over three cycles: FETs off, serious bit 4 set
// [R12] limit register bits 0-3 low bus, 4-7 high bus, same order
// [R13] status registers are byte wide, RW, write protectable, reset zero
// [R14] flags stay set until host writes one to clear; reserved read zero
`timescale 1ns/100ps
module cfs_fault_status_bank (
	input wire logic clock,
	input wire logic rst,
	input wire cfs_pkg::cfs_fault_s fault,
	input wire cfs_pkg::cfs_access_s access,
	input wire logic write_protect,
	output logic [7:0] rd_data_reg,
	output logic rd_valid_reg,
	output logic fet_shutdown_reg,
	output logic location_one_strobe_reg,
	output logic location_two_strobe_reg
);
	logic [7:0] supply_reg, supply_next;
	logic [7:0] ocur_reg, ocur_next;
	logic [7:0] serious_reg, serious_next;
	logic [7:0] limit_reg, limit_next;
	logic [2:0] oc_two_cnt_reg, oc_two_cnt_next;
	logic [2:0] neg_cnt_reg, neg_cnt_next;
	logic [7:0] rd_data_next;
	logic rd_valid_next;
	logic fet_shutdown_next;
	logic loc_one_next, loc_two_next;
	logic wr_ok;
	logic [7:0] set_supply, set_ocur, set_serious, set_limit;
	logic [7:0] ccl_bits;

	// set wins over a clear arriving in the same cycle
	function automatic logic [7:0] sticky(input logic [7:0] old,
		input logic [7:0] set, input logic [7:0] mask,
		input logic clr_hit, input logic [7:0] clr);
		logic [7:0] c;
		c = clr_hit ? clr : 8'h00;
		sticky = ((old & ~c) | set) & mask;
	endfunction

	function automatic logic [2:0] persist(input logic [2:0] cnt,
		input logic cond);
		if (!cond)
			persist = 3'h0;
		else if (cnt == cfs_pkg::PERSIST_TRIP)
			persist = cnt;
		else
			persist = cnt + 3'h1;
	endfunction

	always_comb begin
		wr_ok = access.wr_en && !write_protect; // R13
		set_supply = 8'h00;
		set_supply[cfs_pkg::BIT_GATE_DRIVE_BAD] = fault.gate_drive_supply_bad; // R1
		set_supply[cfs_pkg::BIT_AUX_OV] = fault.aux_micro_regulator_ov; // R2
		set_supply[cfs_pkg::BIT_AUX_UV] = fault.aux_micro_regulator_uv; // R3
		set_ocur = 8'h00;
		set_ocur[cfs_pkg::BIT_OC_ONE] = fault.overcurrent_level_one; // R4
		set_ocur[cfs_pkg::BIT_OC_TWO] = fault.overcurrent_level_two; // R5
		set_ocur[cfs_pkg::BIT_NEG_OC] = fault.negative_overcurrent; // R6
		set_ocur[cfs_pkg::BIT_AVG_LIMIT] = fault.average_current_limit_fault; // R8
		set_ocur[cfs_pkg::BIT_THERMAL] = fault.thermal_over_limit; // R9
		ccl_bits = 8'h00;
		ccl_bits[cfs_pkg::BIT_CCL] = fault.constant_current_loop; // R7
		oc_two_cnt_next = persist(oc_two_cnt_reg, fault.overcurrent_level_two);
		neg_cnt_next = persist(neg_cnt_reg, fault.negative_overcurrent);
		set_serious = 8'h00;
		set_serious[cfs_pkg::BIT_CONT_OC_TWO] =
			(oc_two_cnt_next == cfs_pkg::PERSIST_TRIP); // R10
		set_serious[cfs_pkg::BIT_CONT_NEG_OC] =
			(neg_cnt_next == cfs_pkg::PERSIST_TRIP); // R11
		set_limit = {fault.high_voltage_bus_limit,
			fault.low_voltage_bus_limit}; // R12

		supply_next = sticky(supply_reg, set_supply, cfs_pkg::MASK_SUPPLY,
			wr_ok && access.addr == cfs_pkg::OFF_SUPPLY,
			access.wr_data); // R14
		ocur_next = (sticky(ocur_reg, set_ocur, cfs_pkg::MASK_OVERCURRENT,
			wr_ok && access.addr == cfs_pkg::OFF_OVERCURRENT,
			access.wr_data) & ~(8'h01 << cfs_pkg::BIT_CCL)) | ccl_bits; // R7
		serious_next = sticky(serious_reg, set_serious,
			cfs_pkg::MASK_SERIOUS,
			wr_ok && access.addr == cfs_pkg::OFF_SERIOUS,
			access.wr_data); // R14
		limit_next = sticky(limit_reg, set_limit, cfs_pkg::MASK_BUS_LIMIT,
			wr_ok && access.addr == cfs_pkg::OFF_BUS_LIMIT,
			access.wr_data); // R14

		// external FETs held off while a continuous fault is latched
		fet_shutdown_next = |serious_next; // R10 R11
		loc_one_next = fault.overcurrent_level_one ||
			fault.negative_overcurrent; // R4 R6
		loc_two_next = fault.overcurrent_level_two; // R5

		rd_valid_next = access.rd_en;
		rd_data_next = rd_data_reg;
		if (access.rd_en) begin
			case (access.addr)
				cfs_pkg::OFF_SUPPLY: rd_data_next = supply_reg;
				cfs_pkg::OFF_OVERCURRENT: rd_data_next = ocur_reg;
				cfs_pkg::OFF_SERIOUS: rd_data_next = serious_reg;
				cfs_pkg::OFF_BUS_LIMIT: rd_data_next = limit_reg;
				default: rd_data_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			supply_reg <= cfs_pkg::RESET_VALUE; // R13
			ocur_reg <= cfs_pkg::RESET_VALUE;
			serious_reg <= cfs_pkg::RESET_VALUE;
			limit_reg <= cfs_pkg::RESET_VALUE;
			oc_two_cnt_reg <= 3'h0;
			neg_cnt_reg <= 3'h0;
			rd_data_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
			fet_shutdown_reg <= 1'b0;
			location_one_strobe_reg <= 1'b0;
			location_two_strobe_reg <= 1'b0;
		end else begin
			supply_reg <= supply_next;
			ocur_reg <= ocur_next;
			serious_reg <= serious_next;
			limit_reg <= limit_next;
			oc_two_cnt_reg <= oc_two_cnt_next;
			neg_cnt_reg <= neg_cnt_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			fet_shutdown_reg <= fet_shutdown_next;
			location_one_strobe_reg <= loc_one_next;
			location_two_strobe_reg <= loc_two_next;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	gate_drive_flag_a: assert property ( // R1
		fault.gate_drive_supply_bad |=> supply_reg[0])
		else $error("gate drive flag not set");
	aux_ov_flag_a: assert property ( // R2
		fault.aux_micro_regulator_ov |=> supply_reg[4])
		else $error("aux overvoltage flag not set");
	aux_uv_flag_a: assert property ( // R3
		fault.aux_micro_regulator_uv |=> supply_reg[5])
		else $error("aux undervoltage flag not set");
	oc_one_strobe_a: assert property ( // R4
		fault.overcurrent_level_one |=> ocur_reg[0] && location_one_strobe_reg)
		else $error("level one flag or strobe missing");
	oc_two_strobe_a: assert property ( // R5
		fault.overcurrent_level_two |=> ocur_reg[1] && location_two_strobe_reg)
		else $error("level two flag or strobe missing");
	neg_oc_strobe_a: assert property ( // R6
		fault.negative_overcurrent |=> ocur_reg[2] && location_one_strobe_reg)
		else $error("negative flag or strobe missing");
	ccl_live_a: assert property ( // R7
		##1 ocur_reg[4] == $past(fault.constant_current_loop))
		else $error("ccl bit does not follow loop state");
	avg_limit_flag_a: assert property ( // R8
		fault.average_current_limit_fault |=> ocur_reg[5])
		else $error("average limit flag not set");
	thermal_flag_a: assert property ( // R9
		fault.thermal_over_limit |=> ocur_reg[7])
		else $error("thermal flag not set");
	oc_two_trip_a: assert property ( // R10
		fault.overcurrent_level_two [*4] |=> serious_reg[2] && fet_shutdown_reg)
		else $error("continuous level two did not trip");
	oc_two_early_a: assert property ( // R10
		$rose(serious_reg[2]) |-> $past(fault.overcurrent_level_two, 4) &&
		$past(fault.overcurrent_level_two, 3))
		else $error("level two tripped too early");
	neg_trip_a: assert property ( // R11
		fault.negative_overcurrent [*4] |=> serious_reg[4] && fet_shutdown_reg)
		else $error("continuous negative did not trip");
	neg_early_a: assert property ( // R11
		$rose(serious_reg[4]) |-> $past(fault.negative_overcurrent, 4) &&
		$past(fault.negative_overcurrent, 3))
		else $error("negative tripped too early");
	bus_limit_map_a: assert property ( // R12
		1'b1 |=> (limit_reg & $past({fault.high_voltage_bus_limit,
		fault.low_voltage_bus_limit})) == $past({fault.high_voltage_bus_limit,
		fault.low_voltage_bus_limit}))
		else $error("bus limit flag missing");
	protect_hold_a: assert property ( // R13
		write_protect && supply_reg[4] |=> supply_reg[4])
		else $error("protected flag was cleared");
	sticky_hold_a: assert property ( // R14
		limit_reg[3] && !(access.wr_en && access.addr == cfs_pkg::OFF_BUS_LIMIT)
		|=> limit_reg[3])
		else $error("flag dropped without a clear");
	reserved_zero_a: assert property ( // R14
		(supply_reg & ~cfs_pkg::MASK_SUPPLY) == 8'h00 &&
		(serious_reg & ~cfs_pkg::MASK_SERIOUS) == 8'h00)
		else $error("reserved bit set");
	read_path_a: assert property ( // R13
		access.rd_en && access.addr == cfs_pkg::OFF_SERIOUS
		|=> rd_valid_reg && rd_data_reg == $past(serious_reg))
		else $error("read data mismatch");
	clear_works_a: assert property ( // R14
		access.wr_en && !write_protect &&
		access.addr == cfs_pkg::OFF_BUS_LIMIT && access.wr_data[0] &&
		!fault.low_voltage_bus_limit[0] |=> !limit_reg[0])
		else $error("write one did not clear flag");
	shutdown_level_a: assert property ( // R10
		fet_shutdown_reg == |serious_reg)
		else $error("shutdown does not follow serious flags");
	strobe_two_drop_a: assert property ( // R5
		!fault.overcurrent_level_two |=> !location_two_strobe_reg)
		else $error("level two strobe stuck");
	read_pulse_a: assert property ( // R13
		!access.rd_en |=> !rd_valid_reg)
		else $error("read valid without request");
endmodule

/* cfs_host_model.sv */
// management bus host model driving the fault status bank
`timescale 1ns/100ps
module cfs_host_model (
	input wire logic clock,
	output cfs_pkg::cfs_access_s access,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	initial access = '0;
	// write one byte; ones written to flags clear them
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		access <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wr_data: d};
		@(negedge clock);
		// released lines show the inverse, not the stale value
		access <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wr_data: ~d};
	endtask
	// read answers exactly one cycle after the request edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		@(negedge clock);
		access <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wr_data: 8'h00};
		@(negedge clock);
		ok = rd_valid;
		d = rd_data;
		access <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wr_data: 8'hff};
	endtask
endmodule

/* tb_cfs_fault_status_bank.sv */
// self-checking testbench for the fault status bank
`timescale 1ns/100ps
module tb_cfs_fault_status_bank;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic write_protect = 1'b0;
	cfs_pkg::cfs_fault_s fault = '0;
	cfs_pkg::cfs_access_s access;
	logic [7:0] rd_data;
	logic rd_valid, fet_off, loc_one, loc_two;
	int fails = 0;
	int comparisons = 0;
	always #12.5 clock = ~clock;
	cfs_fault_status_bank cfs_fault_status_bank_inst (.clock(clock),
		.rst(rst), .fault(fault), .access(access),
		.write_protect(write_protect), .rd_data_reg(rd_data),
		.rd_valid_reg(rd_valid), .fet_shutdown_reg(fet_off),
		.location_one_strobe_reg(loc_one),
		.location_two_strobe_reg(loc_two));
	cfs_host_model cfs_host_model_inst (.clock(clock), .access(access),
		.rd_data(rd_data), .rd_valid(rd_valid));
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		cfs_host_model_inst.rd(a, d, ok);
		chk("rd_valid", 8'h01, {7'h0, ok});
		chk($sformatf("reg %h", a), exp, d);
	endtask
	task automatic hold(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic clear_all();
		for (int i = 0; i < 4; i++) cfs_host_model_inst.wr(8'(8'hd4 + i), 8'hff);
	endtask
	task automatic t_reset();
		for (int i = 0; i < 5; i++) rd_chk(i < 4 ? 8'(8'hd4 + i) : 8'h20, 8'h00);
	endtask
	task automatic t_sticky();
		@(negedge clock);
		fault = '1;
		fault.constant_current_loop = 1'b0;
		fault.low_voltage_bus_limit = 4'h2;
		fault.high_voltage_bus_limit = 4'h9;
		@(negedge clock);
		fault = '0;
		chk("level one strobe", 8'h01, {7'h0, loc_one});
		chk("level two strobe", 8'h01, {7'h0, loc_two});
		hold(2);
		rd_chk(8'hd4, 8'h31);
		rd_chk(8'hd5, 8'ha7);
		rd_chk(8'hd6, 8'h00);
		rd_chk(8'hd7, 8'h92);
	endtask
	task automatic t_protect();
		write_protect = 1'b1;
		clear_all();
		rd_chk(8'hd4, 8'h31);
		rd_chk(8'hd5, 8'ha7);
		rd_chk(8'hd7, 8'h92);
		write_protect = 1'b0;
		clear_all();
		for (int i = 0; i < 4; i++) rd_chk(8'(8'hd4 + i), 8'h00);
	endtask
	task automatic t_ccl();
		fault.constant_current_loop = 1'b1;
		hold(2);
		cfs_host_model_inst.wr(8'hd5, 8'h10);
		rd_chk(8'hd5, 8'h10);
		fault.constant_current_loop = 1'b0;
		hold(2);
		rd_chk(8'hd5, 8'h00);
	endtask
	task automatic t_persist(input int n, input bit neg, input logic [7:0] exp);
		@(negedge clock);
		fault.overcurrent_level_two = !neg;
		fault.negative_overcurrent = neg;
		hold(n);
		fault = '0;
		hold(1);
		chk("shutdown", {7'h0, exp != 8'h00}, {7'h0, fet_off});
		rd_chk(8'hd6, exp);
		clear_all();
		rd_chk(8'hd6, 8'h00);
		chk("shutdown released", 8'h00, {7'h0, fet_off});
	endtask
	// a drop in the condition restarts the persistence count
	task automatic t_gap();
		@(negedge clock);
		fault.overcurrent_level_two = 1'b1;
		hold(3);
		fault.overcurrent_level_two = 1'b0;
		hold(1);
		fault.overcurrent_level_two = 1'b1;
		hold(3);
		fault = '0;
		hold(1);
		chk("gap shutdown", 8'h00, {7'h0, fet_off});
		rd_chk(8'hd6, 8'h00);
		clear_all();
	endtask
	// a clear in the same cycle as a live condition loses
	task automatic t_set_wins();
		fault.thermal_over_limit = 1'b1;
		hold(1);
		cfs_host_model_inst.wr(8'hd5, 8'hff);
		rd_chk(8'hd5, 8'h80);
		fault.thermal_over_limit = 1'b0;
		cfs_host_model_inst.wr(8'hd5, 8'hff);
		rd_chk(8'hd5, 8'h00);
	endtask
	// flags latched before a reset in mid-run must come back zero
	task automatic t_midreset();
		@(negedge clock);
		fault.low_voltage_bus_limit = 4'hd;
		fault.high_voltage_bus_limit = 4'h6;
		@(negedge clock);
		fault = '0;
		rd_chk(8'hd7, 8'h6d);
		rst = 1'b1;
		hold(3);
		rst = 1'b0;
		for (int i = 0; i < 4; i++) rd_chk(8'(8'hd4 + i), 8'h00);
	endtask
	task automatic results();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		t_reset();
		t_sticky();
		t_protect();
		t_ccl();
		t_persist(3, 1'b0, 8'h00);
		t_persist(4, 1'b0, 8'h04);
		t_persist(3, 1'b1, 8'h00);
		t_persist(4, 1'b1, 8'h10);
		t_gap();
		t_set_wins();
		t_midreset();
		results();
	end
	// cuts a hang short
	initial begin
		repeat (3000) @(posedge clock);
		fails++;
		results();
	end
endmodule
